/* File: rtl/smcs_ctrl.v */
/*
 * control and status logic of a pluggable optical module: laser off pin,
 * soft laser off bit, fault latch and its reset, signal lost reporting,
 * power-on readiness and a two-wire slave for the two address spaces.
 * assumes all pin inputs are asynchronous and the serial clock is far
 * slower than the core clock; sda is open drain, pulled up outside.
 */
`include "smcs_regs.vh"

module smcs_ctrl #(
	parameter integer RESET_CYC = `SMCS_T_RESET_MS * `SMCS_CLK_KHZ,
	parameter integer SERIAL_CYC = `SMCS_T_SERIAL_MS * `SMCS_CLK_KHZ,
	parameter integer DATA_CYC = `SMCS_T_DATA_MS * `SMCS_CLK_KHZ,
	parameter integer WRITE_CYC = `SMCS_T_WRITE_MS * `SMCS_CLK_KHZ
) (
	input wire i_core_clk,
	input wire i_sys_rst,
	input wire i_laser_off_request,
	input wire i_laser_fault_sense,
	input wire i_signal_present,
	input wire i_monitor_ok,
	input wire i_scl,
	input wire i_sda_i,
	output wire o_sda_o,
	output wire o_sda_oe,
	output wire o_laser_enable,
	output wire o_laser_fault_flag,
	output wire o_signal_lost_flag,
	output wire o_data_ready
);

localparam integer DEPTH = 256;

wire pin_s, fault_s, sig_s, mon_s, scl_s, sda_s;
wire hold_done, serial_done, data_done, wbusy_done;
wire scl_rise, scl_fall, bus_start, bus_stop, pin_fall;
wire rx_done, addr_hit, addr_ack, data_take, ctl_hit, wcycle_start;
wire [7:0] ctl_byte, rd_cur;

reg pin_d_r, scl_d_r, sda_d_r;
reg fault_r, soft_r, laser_r, los_r, ready_r;
reg [2:0] st_r;
reg [1:0] phase_r;
reg [3:0] bit_r, nwr_r;
reg [7:0] sh_r, ptr_r;
reg sel_r, rd_r, oe_r, mack_r, wrote_r;
reg [7:0] id_mem [0:DEPTH-1];
reg [7:0] diag_mem [0:DEPTH-1];
integer i;

// byte served for a read at a given space and pointer
function [7:0] rd_byte;
	input sel;
	input [7:0] p;
	begin
		if (!sel) begin
			rd_byte = id_mem[p];
		end else if (p == `SMCS_CTL_ADDR) begin
			rd_byte = ctl_byte;
		end else begin
			rd_byte = diag_mem[p];
		end
	end
endfunction

smcs_sync #(
	.W(6)
) u_sync (
	.i_core_clk(i_core_clk),
	.i_sys_rst(i_sys_rst),
	.i_async({i_sda_i, i_scl, i_monitor_ok, i_signal_present,
		i_laser_fault_sense, i_laser_off_request}),
	.o_sync({sda_s, scl_s, mon_s, sig_s, fault_s, pin_s})
);

smcs_timer #(
	.W(18),
	.LIMIT(RESET_CYC)
) u_hold (
	.i_core_clk(i_core_clk),
	.i_sys_rst(i_sys_rst),
	.i_clear(~pin_s),
	.o_done(hold_done)
);

smcs_timer #(
	.W(23),
	.LIMIT(SERIAL_CYC)
) u_serial (
	.i_core_clk(i_core_clk),
	.i_sys_rst(i_sys_rst),
	.i_clear(1'b0),
	.o_done(serial_done)
);

smcs_timer #(
	.W(25),
	.LIMIT(DATA_CYC)
) u_data (
	.i_core_clk(i_core_clk),
	.i_sys_rst(i_sys_rst),
	.i_clear(1'b0),
	.o_done(data_done)
);

smcs_timer #(
	.W(18),
	.LIMIT(WRITE_CYC)
) u_wbusy (
	.i_core_clk(i_core_clk),
	.i_sys_rst(i_sys_rst),
	.i_clear(wcycle_start),
	.o_done(wbusy_done)
);

assign pin_fall = pin_d_r & ~pin_s;
assign scl_rise = scl_s & ~scl_d_r;
assign scl_fall = ~scl_s & scl_d_r;
assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
assign bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;
assign wcycle_start = bus_stop & wrote_r;

assign ctl_byte = {pin_s, soft_r, 3'h0, fault_r, los_r, ready_r};
assign rd_cur = rd_byte(sel_r, ptr_r);

always @(posedge i_core_clk) begin
	if (i_sys_rst) begin
		pin_d_r <= 1'b0;
		scl_d_r <= 1'b1;
		sda_d_r <= 1'b1;
	end else begin
		pin_d_r <= pin_s;
		scl_d_r <= scl_s;
		sda_d_r <= sda_s;
	end
end

// laser fault latch and flags
always @(posedge i_core_clk) begin
	if (i_sys_rst) begin
		fault_r <= 1'b0;
		laser_r <= 1'b0;
		los_r <= 1'b0;
		ready_r <= 1'b0;
	end else begin
		if (fault_s) begin
			fault_r <= 1'b1;
		end else if (pin_fall & hold_done) begin
			fault_r <= 1'b0;
		end
		laser_r <= ~(pin_s | soft_r | fault_r | fault_s);
		los_r <= ~sig_s;
		ready_r <= data_done | (mon_s & serial_done);
	end
end

assign rx_done = (st_r == `SMCS_ST_RX) & scl_fall
	& (bit_r == `SMCS_BITS_BYTE);
assign addr_hit = (sh_r[7:1] == `SMCS_DEV_ID)
	| (sh_r[7:1] == `SMCS_DEV_DIAG);
assign addr_ack = addr_hit & serial_done & wbusy_done;
assign data_take = rx_done & (phase_r == `SMCS_PH_DATA)
	& (nwr_r != `SMCS_PAGE_MAX);
assign ctl_hit = sel_r & (ptr_r == `SMCS_CTL_ADDR);

// byte stores of both spaces
always @(posedge i_core_clk) begin
	if (i_sys_rst) begin
		for (i = 0; i < DEPTH; i = i + 1) begin
			id_mem[i] <= 8'h00;
			diag_mem[i] <= 8'h00;
		end
		soft_r <= 1'b0;
	end else if (data_take) begin
		if (!sel_r) begin
			id_mem[ptr_r] <= sh_r;
		end else if (ctl_hit) begin
			soft_r <= sh_r[`SMCS_B_SOFT];
		end else begin
			diag_mem[ptr_r] <= sh_r;
		end
	end
end

// two-wire slave
always @(posedge i_core_clk) begin
	if (i_sys_rst) begin
		st_r <= `SMCS_ST_IDLE;
		phase_r <= `SMCS_PH_ADDR;
		bit_r <= 4'h0;
		nwr_r <= 4'h0;
		sh_r <= 8'h00;
		ptr_r <= 8'h00;
		sel_r <= 1'b0;
		rd_r <= 1'b0;
		oe_r <= 1'b0;
		mack_r <= 1'b0;
		wrote_r <= 1'b0;
	end else if (bus_stop) begin
		st_r <= `SMCS_ST_IDLE;
		oe_r <= 1'b0;
		wrote_r <= 1'b0;
	end else if (bus_start) begin
		st_r <= `SMCS_ST_RX;
		phase_r <= `SMCS_PH_ADDR;
		bit_r <= 4'h0;
		nwr_r <= 4'h0;
		oe_r <= 1'b0;
	end else begin
		case (st_r)
		`SMCS_ST_RX: begin
			if (scl_rise & (bit_r != `SMCS_BITS_BYTE)) begin
				sh_r <= {sh_r[6:0], sda_s};
				bit_r <= bit_r + 4'h1;
			end else if (rx_done) begin
				bit_r <= 4'h0;
				st_r <= `SMCS_ST_ACK;
				case (phase_r)
				`SMCS_PH_ADDR: begin
					sel_r <= sh_r[1];
					rd_r <= sh_r[0];
					phase_r <= `SMCS_PH_PTR;
					oe_r <= addr_ack;
					if (!addr_ack) begin
						st_r <= `SMCS_ST_IDLE;
					end
				end
				`SMCS_PH_PTR: begin
					ptr_r <= sh_r;
					phase_r <= `SMCS_PH_DATA;
					oe_r <= 1'b1;
				end
				default: begin
					if (data_take) begin
						ptr_r <= ptr_r + 8'h01;
						nwr_r <= nwr_r + 4'h1;
						wrote_r <= 1'b1;
						oe_r <= 1'b1;
					end else begin
						st_r <= `SMCS_ST_IDLE;
					end
				end
				endcase
			end
		end
		`SMCS_ST_ACK: begin
			if (scl_fall) begin
				bit_r <= 4'h0;
				if (rd_r) begin
					sh_r <= rd_cur;
					oe_r <= ~rd_cur[7];
					ptr_r <= ptr_r + 8'h01;
					bit_r <= 4'h1;
					st_r <= `SMCS_ST_TX;
				end else begin
					oe_r <= 1'b0;
					st_r <= `SMCS_ST_RX;
				end
			end
		end
		`SMCS_ST_TX: begin
			if (scl_fall) begin
				if (bit_r == `SMCS_BITS_BYTE) begin
					oe_r <= 1'b0;
					st_r <= `SMCS_ST_MACK;
				end else begin
					oe_r <= ~sh_r[6];
					sh_r <= {sh_r[6:0], 1'b0};
					bit_r <= bit_r + 4'h1;
				end
			end
		end
		`SMCS_ST_MACK: begin
			if (scl_rise) begin
				mack_r <= ~sda_s;
			end else if (scl_fall) begin
				if (mack_r) begin
					sh_r <= rd_cur;
					oe_r <= ~rd_cur[7];
					ptr_r <= ptr_r + 8'h01;
					bit_r <= 4'h1;
					st_r <= `SMCS_ST_TX;
				end else begin
					st_r <= `SMCS_ST_IDLE;
				end
			end
		end
		default: begin
			oe_r <= 1'b0;
		end
		endcase
	end
end

// open drain: the pin is only ever pulled low
assign o_sda_o = 1'b0;
assign o_sda_oe = oe_r;
assign o_laser_enable = laser_r;
assign o_laser_fault_flag = fault_r;
assign o_signal_lost_flag = los_r;
assign o_data_ready = ready_r;

endmodule // smcs_ctrl

/* File: rtl/smcs_regs.vh */
/*
 * constants for the module control and status block: timing figures,
 * two-wire device addresses, control byte location and bit fields.
 * assumes inclusion by bare name from every design file that needs it.
 */
`ifndef SMCS_REGS_VH
`define SMCS_REGS_VH

// core clock rate in kHz
`define SMCS_CLK_KHZ 32'h0000_4E20

// times in ms
`define SMCS_T_RESET_MS 32'h0000_000A
`define SMCS_T_SERIAL_MS 32'h0000_012C
`define SMCS_T_DATA_MS 32'h0000_03E8
`define SMCS_T_WRITE_MS 32'h0000_000A

// two-wire device addresses (7 bit)
`define SMCS_DEV_ID 7'h50
`define SMCS_DEV_DIAG 7'h51

// control and status byte in the diagnostic space
`define SMCS_CTL_ADDR 8'h6E
`define SMCS_B_PIN 7
`define SMCS_B_SOFT 6
`define SMCS_B_FAULT 2
`define SMCS_B_LOS 1
`define SMCS_B_READY 0

// bytes per write command and bits per byte
`define SMCS_PAGE_MAX 4'h8
`define SMCS_BITS_BYTE 4'h8

// two-wire states
`define SMCS_ST_IDLE 3'h0
`define SMCS_ST_RX 3'h1
`define SMCS_ST_ACK 3'h2
`define SMCS_ST_TX 3'h3
`define SMCS_ST_MACK 3'h4

// received byte roles
`define SMCS_PH_ADDR 2'h0
`define SMCS_PH_PTR 2'h1
`define SMCS_PH_DATA 2'h2

`endif

/* File: rtl/smcs_sync.v */
/*
 * two flip-flop synchroniser for a group of independent levels.
 * assumes each bit is a slow level from outside the core clock domain.
 * the stages carry no reset: they track the pins while reset is held.
 */
module smcs_sync #(
	parameter integer W = 1
) (
	input wire i_core_clk,
	input wire i_sys_rst,
	input wire [W-1:0] i_async,
	output wire [W-1:0] o_sync
);

reg [W-1:0] meta_r;
reg [W-1:0] sync_r;

// free running so idle levels stand at release, no false edge
always @(posedge i_core_clk) begin
	meta_r <= i_async;
	sync_r <= meta_r;
end

assign o_sync = sync_r;

endmodule // smcs_sync

/* File: rtl/smcs_timer.v */
/*
 * saturating cycle timer: counts from a clear up to a limit and holds.
 * assumes the limit fits in W bits; counting starts again after reset.
 */
module smcs_timer #(
	parameter integer W = 18,
	parameter integer LIMIT = 200000
) (
	input wire i_core_clk,
	input wire i_sys_rst,
	input wire i_clear,
	output wire o_done
);

reg [W-1:0] cnt_r;
wire [31:0] cnt_ext;

assign cnt_ext = {{(32-W){1'b0}}, cnt_r};

always @(posedge i_core_clk) begin
	if (i_sys_rst | i_clear) begin
		cnt_r <= {W{1'b0}};
	end else if (cnt_ext != LIMIT) begin
		cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
	end
end

assign o_done = (cnt_ext == LIMIT);

endmodule // smcs_timer

/* File: dv/smcs_chk.sv */
/*
 checker for smcs_ctrl: pin to flag timing and power-on readiness.
 assumes binding to smcs_ctrl with the counts handed on.
*/
module smcs_chk #(
	parameter int SERIAL_CYC = 500,
	parameter int DATA_CYC = 2000
) (
	input wire i_core_clk,
	input wire i_sys_rst,
	input wire i_laser_off_request,
	input wire i_laser_fault_sense,
	input wire i_signal_present,
	input wire o_sda_oe,
	input wire o_laser_enable,
	input wire o_laser_fault_flag,
	input wire o_signal_lost_flag,
	input wire o_data_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] up_cnt_r;
	always @(posedge i_core_clk) begin
		if (i_sys_rst)
			up_cnt_r <= 16'h0000;
		else if (up_cnt_r != 16'hffff)
			up_cnt_r <= up_cnt_r + 16'h0001;
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_fault_up;
		i_laser_fault_sense [*2];
	endsequence
	chk_off_pin: assert property (
		$rose(i_laser_off_request) |-> ##[1:4] !o_laser_enable)
		else $error("laser stays on after pin rise");
	chk_en_pin: assert property (
		o_laser_enable |-> !$past(i_laser_off_request, 3))
		else $error("laser on while pin high");
	chk_fault_set: assert property (
		s_fault_up |-> ##[0:3] o_laser_fault_flag)
		else $error("fault flag late");
	chk_fault_off: assert property (
		o_laser_fault_flag && $past(o_laser_fault_flag) |-> !o_laser_enable)
		else $error("laser on during fault");
	chk_fault_clr: assert property (
		$fell(o_laser_fault_flag) |-> $past(i_laser_off_request, 3) ||
		$past(i_laser_off_request, 4) || $past(i_laser_off_request, 5))
		else $error("fault cleared without pin");
	chk_los_set: assert property (
		$fell(i_signal_present) |-> ##[1:4] o_signal_lost_flag)
		else $error("lost flag late");
	chk_los_clr: assert property (
		$rose(i_signal_present) |-> ##[1:4] !o_signal_lost_flag)
		else $error("lost flag stuck");
	chk_bus_early: assert property (
		up_cnt_r < SERIAL_CYC - 2 |-> !o_sda_oe && !o_data_ready)
		else $error("bus answers too early");
	chk_rdy_late: assert property (
		up_cnt_r > DATA_CYC + 2 |-> o_data_ready)
		else $error("data ready late");
endmodule // smcs_chk
bind smcs_ctrl smcs_chk #(.SERIAL_CYC(SERIAL_CYC), .DATA_CYC(DATA_CYC)) u_chk (
	.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
	.i_laser_off_request(i_laser_off_request),
	.i_laser_fault_sense(i_laser_fault_sense),
	.i_signal_present(i_signal_present), .o_sda_oe(o_sda_oe),
	.o_laser_enable(o_laser_enable), .o_laser_fault_flag(o_laser_fault_flag),
	.o_signal_lost_flag(o_signal_lost_flag), .o_data_ready(o_data_ready));

/* File: dv/smcs_host.sv */
/*
 host model: two-wire bus master with write and read tasks.
 assumes sda is wired-and with a pull-up; scl rests high between frames.
*/
module smcs_host (
	input wire i_core_clk,
	input wire i_sda,
	output logic o_scl,
	output logic o_sda
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask
	task automatic bit_x(input logic d, output logic r);
		w(2);
		o_sda <= d;
		w(2);
		o_scl <= 1'b1;
		w(4);
		r = i_sda;
		o_scl <= 1'b0;
	endtask
	task automatic byte_x(input logic [7:0] d, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r[i]);
	endtask
	// sda moves while scl high: start or stop
	task automatic cond(input logic s0, input logic s1);
		w(2);
		o_sda <= s0;
		w(2);
		o_scl <= 1'b1;
		w(4);
		o_sda <= s1;
		w(4);
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic [7:0] r;
		logic a;
		byte_x(d, r);
		bit_x(1'b1, a);
		ack = !a;
	endtask
	task automatic begin_x(input logic [7:0] d, output logic ack);
		cond(1'b1, 1'b0);
		o_scl <= 1'b0;
		send(d, ack);
	endtask
	task automatic wr(input logic [6:0] dv, input logic [7:0] p,
		input logic [7:0] d, output logic ack);
		logic a;
		begin_x({dv, 1'b0}, ack);
		if (ack) begin
			send(p, a);
			send(d, a);
		end
		cond(1'b0, 1'b1);
	endtask
	task automatic rd(input logic [6:0] dv, input logic [7:0] p,
		output logic [7:0] d, output logic ack);
		logic a;
		begin_x({dv, 1'b0}, ack);
		send(p, a);
		begin_x({dv, 1'b1}, a);
		byte_x(8'hff, d);
		bit_x(1'b1, a);
		cond(1'b0, 1'b1);
	endtask
endmodule // smcs_host

/* File: dv/smcs_ctrl_tb.sv */
/*
 bench for smcs_ctrl: drives pins, runs the bus through the host model.
 assumes shortened counts and the design header on the include path.
*/
`include "smcs_regs.vh"
module smcs_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int RST_C = 200;
	localparam int SER_C = 500;
	localparam int DAT_C = 12000;
	localparam int WR_C = 300;
	logic clk, rst, off, flt, sig, mon, scl, hsda, oe, en, ff, lf, rdy, ack;
	logic sdo;
	wire sda = hsda & (oe ? sdo : 1'b1);
	logic [7:0] d;
	logic [15:0] rnd = 16'hb27d;
	int fail_count = 0;
	int n_tests = 0;
	smcs_ctrl #(.RESET_CYC(RST_C), .SERIAL_CYC(SER_C), .DATA_CYC(DAT_C),
		.WRITE_CYC(WR_C)) DUT (.i_core_clk(clk), .i_sys_rst(rst),
		.i_laser_off_request(off), .i_laser_fault_sense(flt),
		.i_signal_present(sig), .i_monitor_ok(mon), .i_scl(scl),
		.i_sda_i(sda), .o_sda_o(sdo), .o_sda_oe(oe), .o_laser_enable(en),
		.o_laser_fault_flag(ff), .o_signal_lost_flag(lf), .o_data_ready(rdy));
	smcs_host HOST (.i_core_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(hsda));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [7:0] ctl(input logic p, s, f, l, r);
		return {p, s, 3'h0, f, l, r};
	endfunction
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic test_done;
		if (fail_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic at(input int n);
		tick(n);
		@(negedge clk);
	endtask
	task automatic rd(output logic [7:0] v);
		HOST.rd(`SMCS_DEV_DIAG, `SMCS_CTL_ADDR, v, ack);
	endtask
	task automatic wr(input logic [7:0] v);
		HOST.wr(`SMCS_DEV_DIAG, `SMCS_CTL_ADDR, v, ack);
	endtask
	initial begin
		rst = 1'b1;
		off = 1'b0;
		flt = 1'b0;
		sig = 1'b1;
		mon = 1'b0;
		at(19);
		chk({sdo, oe, en, ff, lf, rdy}, 8'h00);
		rnd = lfsr(rnd);
		@(posedge clk);
		rst <= 1'b0;
		mon <= rnd[0];
		wr(8'h40);
		chk(ack, 1'b0);
		at(SER_C);
		chk({en, rdy}, {1'b1, mon});
		wr(8'h40);
		chk(ack, 1'b1);
		at(1);
		chk(en, 1'b0);
		wr(8'h00);
		chk(ack, 1'b0);
		tick(WR_C);
		rd(d);
		chk(ack, 1'b1);
		chk(d, ctl(1'b0, 1'b1, 1'b0, 1'b0, mon));
		wr(8'h00);
		chk(ack, 1'b1);
		at(1);
		chk(en, 1'b1);
		tick(WR_C);
		for (int i = 0; i < 10; i++) begin
			rnd = lfsr(rnd);
			@(posedge clk);
			sig <= rnd[2];
			off <= rnd[3];
			at(5);
			chk({en, lf}, {!rnd[3], !rnd[2]});
			rd(d);
			chk(d, ctl(rnd[3], 1'b0, 1'b0, !rnd[2], mon));
		end
		@(posedge clk);
		off <= 1'b0;
		sig <= 1'b1;
		flt <= 1'b1;
		at(5);
		chk({ff, en}, 2'b10);
		rd(d);
		chk(d, ctl(1'b0, 1'b0, 1'b1, 1'b0, mon));
		@(posedge clk);
		flt <= 1'b0;
		off <= 1'b1;
		tick(RST_C / 2);
		off <= 1'b0;
		at(5);
		chk(ff, 1'b1);
		@(posedge clk);
		off <= 1'b1;
		tick(RST_C + 4);
		off <= 1'b0;
		at(5);
		chk({ff, en}, 2'b01);
		@(posedge clk);
		mon <= 1'b0;
		at(5);
		chk(rdy, 1'b0);
		at(DAT_C);
		chk(rdy, 1'b1);
		test_done();
	end
	initial begin
		tick(40000);
		fail_count++;
		test_done();
	end
endmodule // smcs_ctrl_tb
